// [rtl/cdbx_exec.sv]
// Executor for memory, stack, atomic, shift and bit instructions
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps

// Functional notes
// - Program byte load copies (Z) into Rd or R0 in 3 cycles; Z+1 form.
// - Extended load addresses high page pointer:Z, 3 cycles, three forms.
// - Program store writes R1:R0 at high page:Z; increment form adds two.
// - I/O in and out take one cycle and leave flags alone.
// - Push takes one cycle, pop two, no flags touched.
// - Load-and-or returns old byte, writes byte OR register, two cycles.
// - Load-and-clear writes byte AND (ff minus register), returns old byte.
// - Load-and-xor writes register XOR byte, returns old byte, two cycles.
// - Rotate left through carry, updates Z C N V H, one cycle.
// - Rotate right through carry, updates Z C N V, one cycle.
// - I/O bit set and clear touch only the chosen bit, one cycle.
// - Bit store copies register bit into T, one cycle.
// - Bit load copies T into register bit, one cycle.
// - Named flag set and clear drive only that flag, one cycle.
// - Data memory counts hold for internal memory; external may stall.
// - Internal SRAM stack accesses take one extra cycle.
module cdbx_exec (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output cdbx_pkg::cdbx_pm_s     pmReq,
    input  wire logic [7:0]        pmRdata,
    input  wire logic              pmAck,
    output cdbx_pkg::cdbx_ram_s    ramReq,
    input  wire logic [7:0]        ramRdata,
    input  wire logic              ramReady,
    output cdbx_pkg::cdbx_io_s     ioReq,
    input  wire logic [7:0]        ioRdata,
    output logic                   busy,
    output logic                   breakPulse,
    output logic                   sleepPulse,
    output logic                   wdtRestart
);
    import cdbx_pkg::*;

    // ============================================================
    // Decode helpers
    function automatic logic isPmLoad(input cdbx_op_e op);
        return op inside {OP_PM_LOAD_R0, OP_PM_LOAD, OP_PM_LOAD_INC,
                          OP_XPM_LOAD_R0, OP_XPM_LOAD, OP_XPM_LOADINC};
    endfunction

    function automatic logic isAtomic(input cdbx_op_e op);
        return op inside {OP_RAM_XCHG, OP_RAM_OR, OP_RAM_CLEAR, OP_RAM_XOR};
    endfunction

    function automatic logic ramWrites(input cdbx_op_e op);
        return isAtomic(op) || op == OP_PUSH;
    endfunction

    function automatic logic ramReads(input cdbx_op_e op);
        return isAtomic(op) || op == OP_POP;
    endfunction

    // Cycles beyond the first; the counter runs down to zero
    function automatic logic [1:0] extraCycles(input cdbx_op_e op);
        if (isPmLoad(op))
            return 2'(CYC_PM_LOAD - 1);
        if (op == OP_POP)
            return 2'(CYC_POP + CYC_SRAM_EXTRA - 1);
        if (op == OP_PUSH)
            return 2'(CYC_PUSH + CYC_SRAM_EXTRA - 1);
        if (isAtomic(op))
            return 2'(CYC_ATOMIC - 1);
        if (op inside {OP_IO_IN, OP_IO_OUT})
            return 2'(CYC_IO - 1);
        return 2'(CYC_SINGLE - 1);
    endfunction

    typedef struct packed {
        cdbx_state_e      st;
        logic [1:0]       cnt;
        cdbx_cmd_s        cmd;
        logic [7:0]       stat;
        logic [15:0]      zptr;
        logic [7:0]       hpp;
        logic [15:0]      sp;
        logic [31:0][7:0] regs;
    } cdbx_core_s;

    cdbx_core_s r;
    cdbx_core_s next_r;

    logic       apbWr;
    logic       mapped;
    logic       stall;
    logic       commit;
    logic       startOp;
    logic [7:0] rdVal;
    logic [7:0] res;
    logic [7:0] bitMask;
    cdbx_op_e   op;

    assign op      = r.cmd.op;
    assign rdVal   = r.regs[r.cmd.rd];
    assign bitMask = 8'h01 << r.cmd.bitSel;
    assign busy    = r.st != ST_IDLE;
    assign apbWr   = psel && penable && pwrite;
    assign mapped  = paddr[7] ||
                     paddr inside {ADDR_CMD, ADDR_STATUS, ADDR_PTR,
                                   ADDR_STACK};

    // ============================================================
    // APB slave: zero wait states; writes while busy are refused
    assign pready  = 1'b1;
    assign pslverr = psel && penable && (!mapped || (pwrite && busy));
    assign startOp = apbWr && !busy && paddr == ADDR_CMD;

    always_comb begin
        prdata = 32'h0000_0000;
        if (psel && penable && !pwrite) begin
            if (paddr[7])
                prdata = {24'h000000, r.regs[paddr[6:2]]};
            else begin
                case (paddr)
                    ADDR_CMD:    prdata = {2'b00, r.cmd.ioAddr, 5'h00,
                                           r.cmd.bitSel, 3'h0, r.cmd.rd,
                                           2'b00, r.cmd.op};
                    ADDR_STATUS: prdata = {23'h000000, busy, r.stat};
                    ADDR_PTR:    prdata = {8'h00, r.hpp, r.zptr};
                    ADDR_STACK:  prdata = {16'h0000, r.sp};
                    default:     prdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // ============================================================
    // Memory and I/O requests
    always_comb begin
        pmReq      = '0;
        ramReq     = '0;
        ioReq      = '0;
        pmReq.addr = {8'h00, r.zptr};
        if (op inside {OP_XPM_LOAD_R0, OP_XPM_LOAD, OP_XPM_LOADINC,
                       OP_PM_STORE, OP_PM_STOREINC})
            pmReq.addr = {r.hpp, r.zptr};
        pmReq.wdata = {r.regs[1], r.regs[0]};
        pmReq.rd    = r.st == ST_EXEC && isPmLoad(op);
        pmReq.wr    = r.st == ST_HOLD;
        ramReq.addr = r.zptr;
        if (op == OP_PUSH)
            ramReq.addr = r.sp;
        else if (op == OP_POP)
            ramReq.addr = r.sp + 16'h0001;
        ramReq.rd = r.st == ST_EXEC && r.cnt == 2'd1 && ramReads(op);
        ramReq.wr = r.st == ST_EXEC && r.cnt == 2'd0 && ramWrites(op);
        case (op)
            OP_RAM_XCHG:  ramReq.wdata = rdVal;
            OP_RAM_OR:    ramReq.wdata = ramRdata | rdVal;
            OP_RAM_CLEAR: ramReq.wdata = ramRdata & ~rdVal;
            OP_RAM_XOR:   ramReq.wdata = ramRdata ^ rdVal;
            default:      ramReq.wdata = rdVal;
        endcase
        ioReq.addr = r.cmd.ioAddr;
        if (r.st == ST_EXEC) begin
            ioReq.rd = op inside {OP_IO_IN, OP_IO_BIT_SET, OP_IO_BIT_CLR};
            ioReq.wr = op inside {OP_IO_OUT, OP_IO_BIT_SET, OP_IO_BIT_CLR};
        end
        case (op)
            OP_IO_BIT_SET: ioReq.wdata = ioRdata | bitMask;
            OP_IO_BIT_CLR: ioReq.wdata = ioRdata & ~bitMask;
            default:       ioReq.wdata = rdVal;
        endcase
    end

    // Data memory reached over the external interface holds the last cycle
    assign stall  = r.st == ST_EXEC && r.cnt == 2'd0 &&
                    (ramReads(op) || ramWrites(op)) && !ramReady;
    assign commit = r.st == ST_EXEC && r.cnt == 2'd0 && !stall;

    assign breakPulse = commit && op == OP_BRK;
    assign sleepPulse = commit && op == OP_SLEEP;
    assign wdtRestart = commit && op == OP_WD_RESTART;

    // ============================================================
    // Next state
    always_comb begin
        next_r = r;
        res    = rdVal;
        // Software may set up pointers and registers only while idle
        if (apbWr && !busy) begin
            if (paddr[7])
                next_r.regs[paddr[6:2]] = pwdata[7:0];
            else begin
                case (paddr)
                    ADDR_CMD: begin
                        next_r.cmd.op     = cdbx_op_e'(pwdata[CMD_OP_LSB +: 6]);
                        next_r.cmd.rd     = pwdata[CMD_RD_LSB +: 5];
                        next_r.cmd.bitSel = pwdata[CMD_BIT_LSB +: 3];
                        next_r.cmd.ioAddr = pwdata[CMD_IO_LSB +: 6];
                        next_r.cnt = extraCycles(
                            cdbx_op_e'(pwdata[CMD_OP_LSB +: 6]));
                        next_r.st  = ST_EXEC;
                    end
                    ADDR_STATUS: next_r.stat = pwdata[7:0];
                    ADDR_PTR: begin
                        next_r.zptr = pwdata[15:0];
                        next_r.hpp  = pwdata[PTR_HPP_LSB +: 8];
                    end
                    ADDR_STACK: next_r.sp = pwdata[15:0];
                    default: ;
                endcase
            end
        end
        case (r.st)
            ST_IDLE: ;
            ST_EXEC: begin
                if (r.cnt != 2'd0)
                    next_r.cnt = r.cnt - 2'd1;
                else if (!stall) begin
                    next_r.st = ST_IDLE;
                    case (op)
                        OP_PM_LOAD_R0, OP_XPM_LOAD_R0:
                            next_r.regs[0] = pmRdata;
                        OP_PM_LOAD, OP_XPM_LOAD:
                            next_r.regs[r.cmd.rd] = pmRdata;
                        OP_PM_LOAD_INC, OP_XPM_LOADINC: begin
                            next_r.regs[r.cmd.rd] = pmRdata;
                            next_r.zptr = r.zptr + 16'h0001;
                        end
                        OP_PM_STORE, OP_PM_STOREINC:
                            next_r.st = ST_HOLD;
                        OP_IO_IN:
                            next_r.regs[r.cmd.rd] = ioRdata;
                        OP_PUSH:
                            next_r.sp = r.sp - 16'h0001;
                        OP_POP: begin
                            next_r.regs[r.cmd.rd] = ramRdata;
                            next_r.sp = r.sp + 16'h0001;
                        end
                        OP_RAM_XCHG, OP_RAM_OR, OP_RAM_CLEAR, OP_RAM_XOR:
                            next_r.regs[r.cmd.rd] = ramRdata;
                        OP_SHL, OP_ROTL_C: begin
                            res = {rdVal[6:0],
                                   op == OP_ROTL_C && r.stat[FLAG_C]};
                            next_r.stat[FLAG_C] = rdVal[7];
                            next_r.stat[FLAG_H] = rdVal[3];
                        end
                        OP_SHR, OP_ROTR_C, OP_SHR_ARITH: begin
                            res = {op == OP_ROTR_C ? r.stat[FLAG_C] :
                                   op == OP_SHR_ARITH && rdVal[7],
                                   rdVal[7:1]};
                            next_r.stat[FLAG_C] = rdVal[0];
                        end
                        OP_NIB_SWAP:
                            next_r.regs[r.cmd.rd] = {rdVal[3:0], rdVal[7:4]};
                        OP_FLAG_SET:
                            next_r.stat[r.cmd.bitSel] = 1'b1;
                        OP_FLAG_CLEAR:
                            next_r.stat[r.cmd.bitSel] = 1'b0;
                        OP_BIT_TO_T:
                            next_r.stat[FLAG_T] = rdVal[r.cmd.bitSel];
                        OP_T_TO_BIT:
                            next_r.regs[r.cmd.rd][r.cmd.bitSel] =
                                r.stat[FLAG_T];
                        default: ;
                    endcase
                    // Shared flag update of the shift family
                    if (op inside {OP_SHL, OP_ROTL_C, OP_SHR, OP_ROTR_C,
                                   OP_SHR_ARITH}) begin
                        next_r.regs[r.cmd.rd] = res;
                        next_r.stat[FLAG_Z] = res == 8'h00;
                        next_r.stat[FLAG_N] = res[7];
                        next_r.stat[FLAG_V] = res[7] ^ next_r.stat[FLAG_C];
                        next_r.stat[FLAG_S] = next_r.stat[FLAG_V] ^ res[7];
                    end
                end
            end
            // Store has no fixed length: wait for the program memory
            ST_HOLD: begin
                if (pmAck) begin
                    next_r.st = ST_IDLE;
                    if (op == OP_PM_STOREINC)
                        next_r.zptr = r.zptr + 16'h0002;
                end
            end
            default: next_r.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r      <= '0;
            r.stat <= STAT_RST;
            r.zptr <= ZPTR_RST;
            r.hpp  <= HPP_RST;
            r.sp   <= SP_RST;
        end else begin
            r <= next_r;
        end
    end

    // ============================================================
    // Checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    chk_pm_load_len: assert property (
        startOp && isPmLoad(cdbx_op_e'(pwdata[5:0]))
        |=> busy [*3] ##1 !busy)
        else $error("program byte load not three cycles");

    chk_ext_address: assert property (
        pmReq.rd && op inside {OP_XPM_LOAD_R0, OP_XPM_LOAD, OP_XPM_LOADINC}
        |-> pmReq.addr == {r.hpp, r.zptr})
        else $error("extended load lacks high page");

    chk_store_inc: assert property (
        r.st == ST_HOLD && pmAck && op == OP_PM_STOREINC
        |=> r.zptr == $past(r.zptr) + 16'h0002)
        else $error("store increment not two");

    chk_io_flags: assert property (
        startOp && pwdata[5:0] == 6'h09 |=> ##1 !busy && $stable(r.stat))
        else $error("I/O read took long or changed flags");

    chk_pop_len: assert property (
        startOp && pwdata[5:0] == 6'h0c && ramReady
        |=> busy ##1 busy ##1 (busy && ramReq.rd == 1'b0) ##1 !busy)
        else $error("pop length wrong");

    chk_clear_data: assert property (
        ramReq.wr && op == OP_RAM_CLEAR
        |-> ramReq.wdata == (ramRdata & (8'hff - rdVal)))
        else $error("load-and-clear writeback wrong");

    chk_rotl_carry: assert property (
        commit && op == OP_ROTL_C
        |=> r.stat[FLAG_C] == $past(rdVal[7])
            && r.regs[$past(r.cmd.rd)][0] == $past(r.stat[FLAG_C]))
        else $error("rotate left carry path wrong");

    chk_rotr_carry: assert property (
        commit && op == OP_ROTR_C
        |=> r.stat[FLAG_C] == $past(rdVal[0])
            && r.regs[$past(r.cmd.rd)][7] == $past(r.stat[FLAG_C]))
        else $error("rotate right carry path wrong");

    chk_bit_store: assert property (
        commit && op == OP_BIT_TO_T
        |=> r.stat[FLAG_T] == $past(rdVal[r.cmd.bitSel])
            && {r.stat[7], r.stat[5:0]} == $past({r.stat[7], r.stat[5:0]}))
        else $error("bit store touched other flags");

    cov_atomic: cover property (commit && op == OP_RAM_OR);
    cov_stall: cover property (stall ##1 commit);
    cov_store: cover property (r.st == ST_HOLD ##1 r.st == ST_IDLE);

endmodule

// [rtl/cdbx_pkg.sv]
// Constants, types and carriers for the data and bit instruction executor
package cdbx_pkg;

    // ============================================================
    // Register map (byte addresses on the APB bus)
    localparam logic [7:0] ADDR_CMD    = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PTR    = 8'h08;
    localparam logic [7:0] ADDR_STACK  = 8'h0c;
    localparam logic [7:0] ADDR_REGS   = 8'h80;

    // ============================================================
    // Field positions
    localparam int CMD_OP_LSB    = 0;
    localparam int CMD_RD_LSB    = 8;
    localparam int CMD_BIT_LSB   = 16;
    localparam int CMD_IO_LSB    = 24;
    localparam int STAT_BUSY_BIT = 8;
    localparam int PTR_HPP_LSB   = 16;

    // ============================================================
    // Reset values
    localparam logic [7:0]  STAT_RST = 8'h00;
    localparam logic [15:0] ZPTR_RST = 16'h0000;
    localparam logic [7:0]  HPP_RST  = 8'h00;
    localparam logic [15:0] SP_RST   = 16'h0fff;

    // ============================================================
    // Status register bit indexes
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    // ============================================================
    // Cycle counts in core clocks
    localparam int CYC_PM_LOAD    = 3;
    localparam int CYC_IO         = 1;
    localparam int CYC_PUSH       = 1;
    localparam int CYC_POP        = 2;
    localparam int CYC_SRAM_EXTRA = 1;
    localparam int CYC_ATOMIC     = 2;
    localparam int CYC_SINGLE     = 1;

    // ============================================================
    // Operations
    typedef enum logic [5:0] {
        OP_NOP         = 6'h00,
        OP_PM_LOAD_R0  = 6'h01,
        OP_PM_LOAD     = 6'h02,
        OP_PM_LOAD_INC = 6'h03,
        OP_XPM_LOAD_R0 = 6'h04,
        OP_XPM_LOAD    = 6'h05,
        OP_XPM_LOADINC = 6'h06,
        OP_PM_STORE    = 6'h07,
        OP_PM_STOREINC = 6'h08,
        OP_IO_IN       = 6'h09,
        OP_IO_OUT      = 6'h0a,
        OP_PUSH        = 6'h0b,
        OP_POP         = 6'h0c,
        OP_RAM_XCHG    = 6'h0d,
        OP_RAM_OR      = 6'h0e,
        OP_RAM_CLEAR   = 6'h0f,
        OP_RAM_XOR     = 6'h10,
        OP_SHL         = 6'h11,
        OP_SHR         = 6'h12,
        OP_ROTL_C      = 6'h13,
        OP_ROTR_C      = 6'h14,
        OP_SHR_ARITH   = 6'h15,
        OP_NIB_SWAP    = 6'h16,
        OP_FLAG_SET    = 6'h17,
        OP_FLAG_CLEAR  = 6'h18,
        OP_IO_BIT_SET  = 6'h19,
        OP_IO_BIT_CLR  = 6'h1a,
        OP_BIT_TO_T    = 6'h1b,
        OP_T_TO_BIT    = 6'h1c,
        OP_BRK         = 6'h1d,
        OP_SLEEP       = 6'h1e,
        OP_WD_RESTART  = 6'h1f
    } cdbx_op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_HOLD = 2'b11
    } cdbx_state_e;

    typedef struct packed {
        cdbx_op_e   op;
        logic [4:0] rd;
        logic [2:0] bitSel;
        logic [5:0] ioAddr;
    } cdbx_cmd_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        rd;
        logic        wr;
    } cdbx_ram_s;

    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] wdata;
        logic        rd;
        logic        wr;
    } cdbx_pm_s;

    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic       rd;
        logic       wr;
    } cdbx_io_s;

endpackage

// [tb/cdbx_mem_model.sv]
// Behavioural program memory, data RAM and I/O space
`timescale 1ns/100ps
module cdbx_mem_model (
    input  wire logic          mclk,
    input  wire logic          slow,
    input  cdbx_pkg::cdbx_pm_s  pmReq,
    output logic [7:0]          pmRdata,
    output logic                pmAck,
    input  cdbx_pkg::cdbx_ram_s ramReq,
    output logic [7:0]          ramRdata,
    output logic                ramReady,
    input  cdbx_pkg::cdbx_io_s  ioReq,
    output logic [7:0]          ioRdata
);
    logic [7:0]  ram [256];
    logic [7:0]  io  [64];
    logic [15:0] pmWord;
    logic [23:0] pmAddr;
    logic        waited;
    // Idle program data is inverted so a stale byte never matches
    assign pmRdata = pmReq.rd ? pmReq.addr[7:0] ^ pmReq.addr[15:8]
                     ^ pmReq.addr[23:16] : ~pmReq.addr[7:0];
    assign ioRdata = io[ioReq.addr];
    // Slow mode holds off a write one cycle, as external RAM would
    assign ramReady = ~slow | waited;
    always @(posedge mclk) begin
        waited <= ramReq.wr & ~ramReady;
        pmAck <= pmReq.wr & ~pmAck;
        if (ramReq.rd)
            ramRdata <= ram[ramReq.addr[7:0]];
        if (ramReq.wr && ramReady)
            ram[ramReq.addr[7:0]] <= ramReq.wdata;
        if (ioReq.wr)
            io[ioReq.addr] <= ioReq.wdata;
        if (pmReq.wr && !pmAck) begin
            pmWord <= pmReq.wdata;
            pmAddr <= pmReq.addr;
        end
    end
endmodule

// [tb/cdbx_exec_tb.sv]
// Self-checking bench for the data and bit instruction executor
`timescale 1ns/100ps
module cdbx_exec_tb;
    import cdbx_pkg::*;
    logic        mclk, rst_n, psel, penable, pwrite, slow, e0;
    logic [7:0]  paddr;
    logic [31:0] pwdata, q0;
    wire  logic [31:0] prdata;
    wire  logic        pready, pslverr, busy, pmAck, ramReady;
    wire  logic [7:0]  pmRdata, ramRdata, ioRdata;
    wire  logic [2:0]  ctl;
    cdbx_pm_s    pmReq;
    cdbx_ram_s   ramReq;
    cdbx_io_s    ioReq;
    logic [2:0]  seen;
    int          failures, cmp_count;
    cdbx_exec cdbx_exec_i (.mclk(mclk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pmReq(pmReq), .pmRdata(pmRdata),
        .pmAck(pmAck), .ramReq(ramReq), .ramRdata(ramRdata),
        .ramReady(ramReady), .ioReq(ioReq), .ioRdata(ioRdata),
        .busy(busy), .breakPulse(ctl[0]), .sleepPulse(ctl[1]),
        .wdtRestart(ctl[2]));
    cdbx_mem_model cdbx_mem_model_i (.mclk(mclk), .slow(slow),
        .pmReq(pmReq), .pmRdata(pmRdata), .pmAck(pmAck),
        .ramReq(ramReq), .ramRdata(ramRdata), .ramReady(ramReady),
        .ioReq(ioReq), .ioRdata(ioRdata));
    // Keeps the last control pulse until a scenario clears it
    always @(negedge mclk) begin
        if (|ctl)
            seen = ctl;
    end
    task automatic test_done;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, x, input string m);
        cmp_count++;
        if (g !== x) begin
            failures++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, g, x);
        end
    endtask
    // Request is held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q0 = prdata;
        e0 = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q0, x, "read");
    endtask
    task automatic setr(input logic [4:0] n, input logic [7:0] v);
        apb(1'b1, ADDR_REGS + {1'b0, n, 2'h0}, {24'h0, v});
    endtask
    task automatic getr(input logic [4:0] n, input logic [7:0] v);
        rd(ADDR_REGS + {1'b0, n, 2'h0}, {24'h0, v});
    endtask
    // Counts busy cycles; n of zero means the count is open
    task automatic run(input cdbx_op_e op, input logic [4:0] r,
        input logic [2:0] b, input logic [5:0] a, input int n);
        int c;
        apb(1'b1, ADDR_CMD, {2'h0, a, 5'h0, b, 3'h0, r, 2'h0, op});
        c = 0;
        @(negedge mclk);
        while (busy === 1'b1 && c < 40) begin
            c++;
            @(negedge mclk);
        end
        if (n != 0)
            chk(c, n, "busy cycles");
    endtask
    task automatic t_reset;
        rd(ADDR_STATUS, 32'h0);
        rd(ADDR_STACK, 32'h0fff);
        rd(8'h40, 32'h0);
        chk(e0, 1'b1, "unmapped error");
        $display("done reset");
    endtask
    task automatic t_pmload;
        apb(1'b1, ADDR_PTR, 32'h0000_34f0);
        run(OP_PM_LOAD_R0, 5'd0, 3'd0, 6'd0, 3);
        getr(5'd0, 8'hc4);
        apb(1'b1, ADDR_PTR, 32'h0012_34f0);
        run(OP_XPM_LOADINC, 5'd3, 3'd0, 6'd0, 3);
        getr(5'd3, 8'hd6);
        rd(ADDR_PTR, 32'h0012_34f1);
        $display("done program load");
    endtask
    task automatic t_atomic;
        cdbx_op_e   ops [4] = '{OP_RAM_XCHG, OP_RAM_OR, OP_RAM_CLEAR,
                                OP_RAM_XOR};
        logic [7:0] x [4] = '{8'h0f, 8'h3f, 8'h30, 8'h33};
        apb(1'b1, ADDR_PTR, 32'h0000_0010);
        for (int i = 0; i < 4; i++) begin
            cdbx_mem_model_i.ram[16] = 8'h3c;
            setr(5'd8, 8'h0f);
            slow = (i == 3);
            run(ops[i], 5'd8, 3'd0, 6'd0, (i == 3) ? 3 : 2);
            slow = 1'b0;
            getr(5'd8, 8'h3c);
            chk(cdbx_mem_model_i.ram[16], x[i], "ram");
        end
        $display("done atomic");
    endtask
    task automatic t_shift;
        cdbx_op_e   ops [5] = '{OP_ROTL_C, OP_ROTR_C, OP_SHL, OP_SHR,
                                OP_SHR_ARITH};
        logic [7:0] si [5] = '{8'h01, 8'h01, 8'h00, 8'h01, 8'h00};
        logic [7:0] rx [5] = '{8'h03, 8'hc0, 8'h02, 8'h40, 8'hc0};
        logic [7:0] sx [5] = '{8'h19, 8'h15, 8'h19, 8'h19, 8'h15};
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, ADDR_STATUS, {24'h0, si[i]});
            setr(5'd2, 8'h81);
            run(ops[i], 5'd2, 3'd0, 6'd0, 1);
            getr(5'd2, rx[i]);
            rd(ADDR_STATUS, {24'h0, sx[i]});
        end
        setr(5'd11, 8'ha5);
        run(OP_NIB_SWAP, 5'd11, 3'd0, 6'd0, 1);
        getr(5'd11, 8'h5a);
        $display("done shift");
    endtask
    task automatic t_flags;
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, ADDR_STATUS, 32'h0);
            run(OP_FLAG_SET, 5'd0, 3'(s), 6'd0, 1);
            rd(ADDR_STATUS, 32'h1 << s);
            apb(1'b1, ADDR_STATUS, 32'hff);
            run(OP_FLAG_CLEAR, 5'd0, 3'(s), 6'd0, 1);
            rd(ADDR_STATUS, 32'hff & ~(32'h1 << s));
        end
        $display("done flags");
    endtask
    task automatic t_bits;
        apb(1'b1, ADDR_STATUS, 32'h0);
        cdbx_mem_model_i.io[5] = 8'h10;
        run(OP_IO_BIT_SET, 5'd0, 3'd0, 6'd5, 1);
        run(OP_IO_BIT_CLR, 5'd0, 3'd4, 6'd5, 1);
        chk(cdbx_mem_model_i.io[5], 8'h01, "io bit");
        setr(5'd9, 8'h5a);
        run(OP_IO_OUT, 5'd9, 3'd0, 6'd7, 1);
        run(OP_IO_IN, 5'd10, 3'd0, 6'd7, 1);
        getr(5'd10, 8'h5a);
        rd(ADDR_STATUS, 32'h0);
        setr(5'd4, 8'h08);
        run(OP_BIT_TO_T, 5'd4, 3'd3, 6'd0, 1);
        rd(ADDR_STATUS, 32'h40);
        setr(5'd7, 8'h81);
        run(OP_T_TO_BIT, 5'd7, 3'd6, 6'd0, 1);
        getr(5'd7, 8'hc1);
        $display("done bits");
    endtask
    task automatic t_stack;
        setr(5'd5, 8'ha5);
        run(OP_PUSH, 5'd5, 3'd0, 6'd0, 2);
        chk(cdbx_mem_model_i.ram[255], 8'ha5, "push");
        rd(ADDR_STACK, 32'h0ffe);
        run(OP_POP, 5'd6, 3'd0, 6'd0, 3);
        getr(5'd6, 8'ha5);
        rd(ADDR_STACK, 32'h0fff);
        $display("done stack");
    endtask
    task automatic t_store;
        setr(5'd0, 8'h34);
        setr(5'd1, 8'h12);
        apb(1'b1, ADDR_PTR, 32'h0003_0100);
        run(OP_PM_STOREINC, 5'd0, 3'd0, 6'd0, 0);
        chk(cdbx_mem_model_i.pmWord, 16'h1234, "store word");
        chk(cdbx_mem_model_i.pmAddr, 24'h030100, "store addr");
        rd(ADDR_PTR, 32'h0003_0102);
        $display("done store");
    endtask
    task automatic t_busy;
        apb(1'b1, ADDR_PTR, 32'h0000_0020);
        apb(1'b1, ADDR_CMD, {26'h0, OP_PM_LOAD_R0});
        apb(1'b1, ADDR_PTR, 32'h0000_ffff);
        chk(e0, 1'b1, "write while busy");
        run(OP_NOP, 5'd0, 3'd0, 6'd0, 1);
        rd(ADDR_PTR, 32'h0000_0020);
        $display("done busy");
    endtask
    task automatic t_ctl;
        cdbx_op_e   ops [4] = '{OP_BRK, OP_SLEEP, OP_WD_RESTART, OP_NOP};
        logic [2:0] px [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
        apb(1'b1, ADDR_STATUS, 32'ha5);
        for (int i = 0; i < 4; i++) begin
            seen = 3'h0;
            run(ops[i], 5'd0, 3'd0, 6'd0, 1);
            chk(seen, px[i], "control pulse");
        end
        rd(ADDR_STATUS, 32'ha5);
        $display("done control");
    endtask
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        slow = 1'b0;
        failures = 0;
        cmp_count = 0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset;
        t_pmload;
        t_atomic;
        t_shift;
        t_flags;
        t_bits;
        t_stack;
        t_store;
        t_busy;
        t_ctl;
        test_done;
    end
    // About twenty times the expected run length
    initial begin
        #40000;
        failures++;
        test_done;
    end
endmodule
